// [hdl/perf_second_monitor.sv]
// Purpose: per-second grading, unavailable-time tracking, sequence check
// Assumes: power_ok low while the instrument has no power
// Notes: counts are provisional until a ten-second window is confirmed
// Functional notes
// - count measured seconds, skipping power loss
// - available equals total minus unavailable
// - errored second on any pattern error
// - severe second on ratio 1e-3, frame/signal loss
// - alarm second on link down, fault, frame loss
// - ten severe or alarm seconds enter unavailability, backdated
// - ten non-severe seconds leave unavailability, backdated
// - pending entry seconds not counted unavailable
// - pending exit counted unavailable, then corrected
// - error-free second when nothing went wrong
// - carry sequence number, expect next one
// - check sequence over runs of four frames
// - single swapped frame gives sequence error
// - other mismatch gives sequence sync loss
// - latency valid only from 0 to 20 s
`timescale 1ns/1ps
module perf_second_monitor
    import perf_mon_pkg::*;
#(
    parameter int unsigned TICK_COUNT = TICK_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic clock_enable,
    // measurement control
    input wire logic measure_start,
    input wire logic power_ok,
    // per-second observations, same domain
    input wire perf_mon_pkg::second_in_t observed,
    // sent and received test frames, latency
    input wire perf_mon_pkg::seq_in_t rx_frame,
    input wire logic tx_frame_take,
    input wire logic [39:0] latency_ns,
    // results
    output logic [15:0] tx_sequence,
    output perf_mon_pkg::counts_t counts,
    output perf_mon_pkg::seq_out_t seq_flags,
    output logic [39:0] latency_report,
    output logic latency_na,
    output logic second_tick
);
    import perf_mon_pkg::*;

    // refused at elaboration: the strobe needs at least two cycles
    if (TICK_COUNT < 2) begin : g_tick_check
        $error("TICK_COUNT too small");
    end

    typedef struct packed {
        logic [31:0] tick_cnt;
        logic tick;
        counts_t cnt;
        avail_state_t mode;
        logic [3:0] run_len;
        grade_t [WINDOW_SECONDS-1:0] hist;
        logic [15:0] tx_seq;
        logic [15:0] expect_seq;
        logic seq_locked;
        logic [1:0] run_pos;
        logic run_bad;
        logic skip_pend;
        seq_out_t flags;
        logic [39:0] lat;
        logic lat_na;
    } state_t;

    state_t cur;
    state_t next_cur;

    // sum a grade field over the window
    function automatic logic [31:0] tally(
        input grade_t [WINDOW_SECONDS-1:0] h, input int unsigned field);
        logic [31:0] s;
        s = 32'h0;
        for (int i = 0; i < WINDOW_SECONDS; i++) begin
            s = s + 32'(h[i][field]);
        end
        return s;
    endfunction

    grade_t g;
    logic bad;
    logic [63:0] err_scaled;

    always_comb begin
        next_cur = cur;
        next_cur.tick = 1'b0;
        err_scaled = 64'(observed.pattern_errors) * 64'(SEVERE_RATIO_INV);
        g.errored = observed.pattern_errors != 32'h0;
        g.severe = (observed.pattern_bits != 32'h0
            && err_scaled >= 64'(observed.pattern_bits))
            || observed.frame_loss_alarm || observed.no_input_signal;
        g.alarm = observed.link_down || observed.remote_fault
            || observed.frame_loss_alarm;
        g.clean = !(g.errored || g.severe || g.alarm);
        bad = g.severe || g.alarm;

        // one-second strobe from the system clock
        if (cur.tick_cnt == TICK_COUNT - 1) begin
            next_cur.tick_cnt = 32'h0;
            next_cur.tick = 1'b1;
        end else begin
            next_cur.tick_cnt = cur.tick_cnt + 32'h1;
        end

        // power loss seconds are simply not graded
        if (cur.tick && power_ok) begin
            next_cur.cnt.total_measure_time =
                cur.cnt.total_measure_time + 32'h1;
            next_cur.hist = {cur.hist[WINDOW_SECONDS-2:0], g};
            case (cur.mode)
                AVAILABLE: begin
                    // pending entry seconds counted as available
                    if (bad) begin
                        next_cur.run_len = cur.run_len + 4'h1;
                    end else begin
                        next_cur.run_len = 4'h0;
                    end
                    next_cur.cnt.errored_second_count =
                        cur.cnt.errored_second_count + 32'(g.errored);
                    next_cur.cnt.severe_error_second_count =
                        cur.cnt.severe_error_second_count + 32'(g.severe);
                    next_cur.cnt.alarm_second_count =
                        cur.cnt.alarm_second_count + 32'(g.alarm);
                    next_cur.cnt.error_free_second_count =
                        cur.cnt.error_free_second_count + 32'(g.clean);
                    if (bad && cur.run_len == 4'(WINDOW_SECONDS - 1)) begin
                        // backdate start, move ten seconds out
                        next_cur.mode = UNAVAILABLE;
                        next_cur.run_len = 4'h0;
                        next_cur.cnt.unavailable_time =
                            cur.cnt.unavailable_time + 32'(WINDOW_SECONDS);
                        next_cur.cnt.errored_second_count =
                            next_cur.cnt.errored_second_count
                            - tally(next_cur.hist, 3);
                        next_cur.cnt.severe_error_second_count =
                            next_cur.cnt.severe_error_second_count
                            - tally(next_cur.hist, 2);
                        next_cur.cnt.alarm_second_count =
                            next_cur.cnt.alarm_second_count
                            - tally(next_cur.hist, 1);
                    end
                end
                UNAVAILABLE: begin
                    // pending exit seconds counted unavailable
                    next_cur.cnt.unavailable_time =
                        cur.cnt.unavailable_time + 32'h1;
                    if (!g.severe) begin
                        next_cur.run_len = cur.run_len + 4'h1;
                    end else begin
                        next_cur.run_len = 4'h0;
                    end
                    if (!g.severe
                        && cur.run_len == 4'(WINDOW_SECONDS - 1)) begin
                        // backdate end to the first second of the run
                        next_cur.mode = AVAILABLE;
                        next_cur.run_len = 4'h0;
                        next_cur.cnt.unavailable_time =
                            cur.cnt.unavailable_time + 32'h1
                            - 32'(WINDOW_SECONDS);
                        next_cur.cnt.errored_second_count =
                            cur.cnt.errored_second_count
                            + tally(next_cur.hist, 3);
                        next_cur.cnt.severe_error_second_count =
                            cur.cnt.severe_error_second_count
                            + tally(next_cur.hist, 2);
                        next_cur.cnt.alarm_second_count =
                            cur.cnt.alarm_second_count
                            + tally(next_cur.hist, 1);
                        next_cur.cnt.error_free_second_count =
                            cur.cnt.error_free_second_count
                            + tally(next_cur.hist, 0);
                    end
                end
                default: begin
                    next_cur.mode = AVAILABLE;
                end
            endcase
        end
        next_cur.cnt.available_time = next_cur.cnt.total_measure_time
            - next_cur.cnt.unavailable_time;

        next_cur.flags = '0;
        if (rx_frame.valid) begin
            next_cur.expect_seq = rx_frame.number + 16'h1;
            next_cur.seq_locked = 1'b1;
            next_cur.skip_pend = 1'b0;
            next_cur.run_pos = cur.run_pos + 2'h1;
            if (cur.skip_pend) begin
                // skipped number turning up now: a plain swap
                if (rx_frame.number == cur.expect_seq - 16'h2) begin
                    next_cur.flags.sequence_error = 1'b1;
                    next_cur.expect_seq = cur.expect_seq;
                end else begin
                    next_cur.flags.sequence_sync_loss = 1'b1;
                end
            end else if (cur.seq_locked
                && rx_frame.number != cur.expect_seq) begin
                // one ahead with run_bad clear is swap or loss; judged on the next frame,
                // so a skip with no later frame stays unjudged
                if (rx_frame.number == cur.expect_seq + 16'h1
                    && !cur.run_bad) begin
                    next_cur.skip_pend = 1'b1;
                end else begin
                    next_cur.flags.sequence_sync_loss = 1'b1;
                end
                next_cur.run_bad = 1'b1;
            end
            if (cur.run_pos == 2'(SEQ_RUN_FRAMES - 1)) begin
                next_cur.run_bad = 1'b0;
            end
        end

        if (measure_start) begin
            next_cur = '0;
            next_cur.mode = AVAILABLE;
        end

        // frame number and latency lie outside the measurement,
        // so a start must not swallow a take or a sample
        next_cur.tx_seq = cur.tx_seq + 16'(tx_frame_take);

        // latency beyond range shown as not available
        next_cur.lat_na = latency_ns > LATENCY_MAX_NS;
        next_cur.lat = next_cur.lat_na ? 40'h0 : latency_ns;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cur <= '0;
        end else if (clock_enable) begin
            cur <= next_cur;
        end
    end

    assign tx_sequence = cur.tx_seq;
    assign counts = cur.cnt;
    assign seq_flags = cur.flags;
    assign latency_report = cur.lat;
    assign latency_na = cur.lat_na;
    assign second_tick = cur.tick;
endmodule

// [hdl/perf_mon_pkg.sv]
// Purpose: shared types and constants for the second and sequence monitor
// Assumes: 25 MHz system clock
// Notes: counts are 32 bits wide
package perf_mon_pkg;
    localparam int unsigned CLOCK_HZ = 25000000;
    localparam int unsigned SECOND_NS = 1000000000;
    localparam int unsigned CLOCK_PERIOD_NS = SECOND_NS / CLOCK_HZ;
    localparam int unsigned TICK_CYCLES = SECOND_NS / CLOCK_PERIOD_NS;
    localparam int unsigned WINDOW_SECONDS = 10;
    localparam int unsigned SEQ_RUN_FRAMES = 4;
    localparam int unsigned LATENCY_MAX_S = 20;
    localparam logic [39:0] LATENCY_MAX_NS = 40'h04_a817_c800;
    // severe when errors * 1000 >= bits (ratio 1e-3)
    localparam logic [31:0] SEVERE_RATIO_INV = 32'h0000_03e8;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [15:0] SEQ_RESET = 16'h0000;

    typedef enum logic [1:0] {
        AVAILABLE = 2'b00,
        UNAVAILABLE = 2'b01
    } avail_state_t;

    typedef struct packed {
        logic link_down;
        logic remote_fault;
        logic frame_loss_alarm;
        logic no_input_signal;
        logic [31:0] pattern_errors;
        logic [31:0] pattern_bits;
    } second_in_t;

    typedef struct packed {
        logic [31:0] total_measure_time;
        logic [31:0] available_time;
        logic [31:0] unavailable_time;
        logic [31:0] errored_second_count;
        logic [31:0] severe_error_second_count;
        logic [31:0] alarm_second_count;
        logic [31:0] error_free_second_count;
    } counts_t;

    typedef struct packed {
        logic valid;
        logic [15:0] number;
    } seq_in_t;

    typedef struct packed {
        logic sequence_error;
        logic sequence_sync_loss;
    } seq_out_t;

    // per-second grade held in the ten-entry history
    typedef struct packed {
        logic errored;
        logic severe;
        logic alarm;
        logic clean;
    } grade_t;
endpackage

// [bench/perf_check_monitor.sv]
// Purpose: port checker for the second and sequence monitor
// Assumes: bench drops clock_enable once while no tick is due
// Notes: counts checked one cycle after their cause
`timescale 1ns/1ps
module perf_check
    import perf_mon_pkg::*;
#(
    parameter int unsigned TICK_COUNT = TICK_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic clock_enable,
    // inputs
    input wire logic measure_start,
    input wire logic power_ok,
    input wire perf_mon_pkg::seq_in_t rx_frame,
    input wire logic tx_frame_take,
    input wire logic [39:0] latency_ns,
    // outputs
    input wire logic [15:0] tx_sequence,
    input wire perf_mon_pkg::counts_t counts,
    input wire perf_mon_pkg::seq_out_t seq_flags,
    input wire logic [39:0] latency_report,
    input wire logic latency_na,
    input wire logic second_tick
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic live;
    assign live = clock_enable && !measure_start;
    property p_avail;
        counts.available_time ==
            counts.total_measure_time - counts.unavailable_time;
    endproperty
    a_avail: assert property (p_avail)
        else $error("available time mismatch");
    property p_total;
        second_tick && power_ok && live |=> counts.total_measure_time ==
            $past(counts.total_measure_time) + 32'h1;
    endproperty
    a_total: assert property (p_total)
        else $error("total time did not advance");
    property p_nopower;
        second_tick && !power_ok && live |=> $stable(counts);
    endproperty
    a_nopower: assert property (p_nopower)
        else $error("unpowered second was counted");
    property p_hold;
        !$past(second_tick) && !$past(measure_start) |-> $stable(counts);
    endproperty
    a_hold: assert property (p_hold)
        else $error("counts moved between seconds");
    property p_start;
        measure_start && clock_enable |=> counts == '0;
    endproperty
    a_start: assert property (p_start)
        else $error("start did not clear counts");
    property p_excl;
        !(seq_flags.sequence_error && seq_flags.sequence_sync_loss);
    endproperty
    a_excl: assert property (p_excl)
        else $error("both sequence flags at once");
    property p_cause;
        (seq_flags != 2'b00) |-> $past(rx_frame.valid);
    endproperty
    a_cause: assert property (p_cause)
        else $error("sequence flag without a frame");
    property p_tx;
        tx_frame_take && clock_enable |=>
            tx_sequence == $past(tx_sequence) + 16'h1;
    endproperty
    a_tx: assert property (p_tx)
        else $error("sequence number did not advance");
    property p_lat_na;
        clock_enable && latency_ns > LATENCY_MAX_NS |=>
            latency_na && latency_report == 40'h0;
    endproperty
    a_lat_na: assert property (p_lat_na)
        else $error("out of range latency reported");
    property p_lat_ok;
        clock_enable && latency_ns <= LATENCY_MAX_NS |=>
            !latency_na && latency_report == $past(latency_ns);
    endproperty
    a_lat_ok: assert property (p_lat_ok)
        else $error("latency in range not reported");
endmodule
bind perf_second_monitor perf_check #(.TICK_COUNT(TICK_COUNT)) u_chk (
    .clock(clock), .rst(rst), .clock_enable(clock_enable),
    .measure_start(measure_start), .power_ok(power_ok),
    .rx_frame(rx_frame), .tx_frame_take(tx_frame_take),
    .latency_ns(latency_ns), .tx_sequence(tx_sequence),
    .counts(counts), .seq_flags(seq_flags),
    .latency_report(latency_report), .latency_na(latency_na),
    .second_tick(second_tick));

// [bench/net_model.sv]
// Purpose: network under test returning generated test frames
// Assumes: one frame handed back per cycle at most
// Notes: drop loses a frame, swap delays it past the next one
`timescale 1ns/1ps
module net_model
    import perf_mon_pkg::*;
(
    // frames out and back
    input wire logic clock,
    input wire logic take,
    input wire logic [15:0] number,
    input wire logic drop,
    input wire logic swap,
    output perf_mon_pkg::seq_in_t rx
);
    logic [15:0] q[$];
    logic [15:0] held;
    logic hold = 1'b0;
    initial rx = '0;
    always @(posedge clock) begin
        // idle number toggles so a stale value never looks valid
        if (q.size() > 0) rx <= {1'b1, q.pop_front()};
        else rx <= {1'b0, ~rx.number};
        if (take && !drop && swap) begin
            held <= number;
            hold <= 1'b1;
        end else if (take && !drop) begin
            q.push_back(number);
            if (hold) q.push_back(held);
            hold <= 1'b0;
        end
    end
endmodule

// [bench/tb_top.sv]
// Purpose: self-checking bench for the second and sequence monitor
// Assumes: ten-cycle seconds
// Notes: expectations worked by hand from the grading rules
`timescale 1ns/1ps
module tb_top;
    import perf_mon_pkg::*;
    logic clock = 1'b0, rst = 1'b1, measure_start = 1'b0, power_ok = 1'b1;
    logic take = 1'b0, drop = 1'b0, swap = 1'b0, latency_na, second_tick;
    logic ce = 1'b1;
    second_in_t observed = '0;
    seq_in_t rx_frame;
    logic [39:0] latency_ns = 40'h0, latency_report;
    logic [15:0] tx_sequence;
    counts_t counts;
    seq_out_t seq_flags;
    int bad_count = 0, n_checks = 0, n_err = 0, n_loss = 0, i;
    always #20 clock = ~clock;
    always @(posedge clock) begin
        n_err <= n_err + int'(seq_flags.sequence_error === 1'b1);
        n_loss <= n_loss + int'(seq_flags.sequence_sync_loss === 1'b1);
    end
    perf_second_monitor #(.TICK_COUNT(10)) u_perf_second_monitor (
        .clock(clock), .rst(rst), .clock_enable(ce),
        .measure_start(measure_start), .power_ok(power_ok),
        .observed(observed), .rx_frame(rx_frame), .tx_frame_take(take),
        .latency_ns(latency_ns), .tx_sequence(tx_sequence),
        .counts(counts), .seq_flags(seq_flags),
        .latency_report(latency_report), .latency_na(latency_na),
        .second_tick(second_tick));
    net_model u_net_model (.clock(clock), .take(take),
        .number(tx_sequence), .drop(drop), .swap(swap), .rx(rx_frame));
    task chk(input string what, input logic [223:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task start;
        @(posedge clock) measure_start <= 1'b1;
        @(posedge clock) measure_start <= 1'b0;
    endtask
    // one graded second; counts settle one edge after the tick
    task sec(input second_in_t o, input logic pw);
        int k;
        @(posedge clock) observed <= o;
        power_ok <= pw;
        for (k = 0; k < 30 && second_tick !== 1'b1; k++) @(negedge clock);
        if (k == 30) bad_count++;
        @(negedge clock);
    endtask
    task exp_c(input logic [31:0] t, u, e, s, l, f);
        chk("counts", counts, {t, t - u, u, e, s, l, f});
    endtask
    task t_grade;
        second_in_t o;
        o = '0;
        sec(o, 1'b1);
        exp_c(1, 0, 0, 0, 0, 1);
        o.pattern_errors = 32'h1;
        o.pattern_bits = 32'h2710;
        sec(o, 1'b1);
        exp_c(2, 0, 1, 0, 0, 1);
        o.pattern_errors = 32'ha;
        sec(o, 1'b1);
        exp_c(3, 0, 2, 1, 0, 1);
        o = '0;
        o.link_down = 1'b1;
        sec(o, 1'b1);
        o = '0;
        o.remote_fault = 1'b1;
        sec(o, 1'b1);
        exp_c(5, 0, 2, 1, 2, 1);
        o = '0;
        sec(o, 1'b0);
        exp_c(5, 0, 2, 1, 2, 1);
        $display("test grade done");
    endtask
    task t_uat;
        second_in_t o;
        o = '0;
        // clean second first: the bad run must start from zero
        sec(o, 1'b1);
        exp_c(6, 0, 2, 1, 2, 2);
        o.frame_loss_alarm = 1'b1;
        for (i = 0; i < 9; i++) sec(o, 1'b1);
        exp_c(15, 0, 2, 10, 11, 2);
        sec(o, 1'b1);
        exp_c(16, 10, 2, 1, 2, 2);
        o = '0;
        for (i = 0; i < 9; i++) sec(o, 1'b1);
        exp_c(25, 19, 2, 1, 2, 2);
        sec(o, 1'b1);
        exp_c(26, 10, 2, 1, 2, 12);
        $display("test unavailable done");
    endtask
    // twenty frozen cycles would hold two ticks if enable were ignored
    task t_freeze;
        @(posedge clock) ce <= 1'b0;
        repeat (20) @(posedge clock);
        @(negedge clock);
        exp_c(26, 10, 2, 1, 2, 12);
        chk("tick frozen", second_tick, 0);
        ce <= 1'b1;
        $display("test freeze done");
    endtask
    task snd(input logic d, s);
        @(posedge clock) take <= 1'b1;
        drop <= d;
        swap <= s;
    endtask
    task t_seq;
        int e0;
        int l0;
        start();
        for (i = 0; i < 8; i++) snd(1'b0, 1'b0);
        repeat (4) @(posedge clock) take <= 1'b0;
        chk("clean flags", n_err + n_loss, 0);
        e0 = n_err;
        l0 = n_loss;
        snd(1'b0, 1'b1);
        for (i = 0; i < 3; i++) snd(1'b0, 1'b0);
        repeat (4) @(posedge clock) take <= 1'b0;
        chk("swap error", n_err > e0 && n_loss == l0, 1);
        e0 = n_err;
        l0 = n_loss;
        snd(1'b1, 1'b0);
        for (i = 0; i < 3; i++) snd(1'b0, 1'b0);
        repeat (4) @(posedge clock) {take, drop} <= 2'b00;
        chk("drop loss", n_loss > l0 && n_err == e0, 1);
        $display("test sequence done");
    endtask
    task t_lat;
        @(posedge clock) latency_ns <= LATENCY_MAX_NS;
        @(posedge clock) latency_ns <= LATENCY_MAX_NS + 40'h1;
        @(negedge clock);
        chk("latency max", {latency_na, latency_report},
            {1'b0, LATENCY_MAX_NS});
        @(negedge clock);
        chk("latency over", {latency_na, latency_report},
            41'h1_00_0000_0000);
        $display("test latency done");
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        start();
        t_grade();
        t_uat();
        t_freeze();
        t_seq();
        t_lat();
        final_report();
    end
    initial begin
        #100000;
        bad_count++;
        final_report();
    end
endmodule
